// File: inc/rtc_pkg.sv
// Shared register map, field layout, reset values and timing for the clock/watchdog/status block
`default_nettype none

package rtc_pkg;

  // Register indexes; write opcode = index, read opcode = index + 8'h80
  localparam logic [6:0] REG_SECONDS  = 7'h30; // [15:8] hundredths (tenths digit high), [7:0] seconds
  localparam logic [6:0] REG_MINS_HRS = 7'h31; // [15:8] minutes, [7:0] hours
  localparam logic [6:0] REG_DAY_DATE = 7'h32; // [15:8] day of week, [7:0] date
  localparam logic [6:0] REG_MON_YEAR = 7'h33; // [15:8] month, [7:0] year
  localparam logic [6:0] REG_WATCHDOG = 7'h34; // watchdog_countdown, 4 BCD digits of 10 ms
  localparam logic [6:0] REG_ALARM    = 7'h35; // [15:8] alarm minutes, [7:0] alarm hours
  localparam logic [6:0] REG_RTC_CTRL = 7'h36; // match enables, watchdog enable/flag, case flag
  localparam logic [6:0] REG_CAL_CTRL = 7'h37; // interrupt enable, timeout select
  localparam logic [6:0] REG_CAL_INT  = 7'h38; // read only
  localparam logic [6:0] REG_CAL_FRAC = 7'h39; // read only
  localparam logic [6:0] REG_STATUS   = 7'h3a; // read only, cleared by reading

  // Opcode ranges
  localparam logic [7:0] WR_OP_FIRST = 8'h30;
  localparam logic [7:0] WR_OP_LAST  = 8'h43;
  localparam logic [7:0] RD_OP_FIRST = 8'hb0;

  // Field positions
  localparam int HOUR_FORMAT_BIT = 6; // 1 = 12-hour
  localparam int HOUR_PM_BIT     = 5; // PM in 12-hour, twenty-hours digit in 24-hour
  localparam int CTRL_AM1_BIT    = 0;
  localparam int CTRL_AM2_BIT    = 1;
  localparam int CTRL_WDEN_BIT   = 2;
  localparam int CTRL_WF_BIT     = 3;
  localparam int CTRL_CASE_SWITCH_CONTROL_FLAG_BIT   = 4;
  localparam int CAL_INTEN_BIT   = 15;
  localparam int CAL_TOSEL_LSB   = 0;  // three bits
  localparam int ST_CAL_BIT      = 0;
  localparam int ST_TO_BIT       = 1;
  localparam int ST_AF_BIT       = 2;
  localparam int ST_CASE_SWITCH_IRQ_FLAG_BIT     = 3;
  localparam int STATUS_W        = 4;

  // Reset values
  localparam logic [15:0] SECONDS_RST  = 16'h0000;
  localparam logic [15:0] MINS_HRS_RST = 16'h0000;
  localparam logic [15:0] DAY_DATE_RST = 16'h0001;
  localparam logic [15:0] MON_YEAR_RST = 16'h0100;
  localparam logic [15:0] WATCHDOG_RST = 16'h0000;
  localparam logic [15:0] ALARM_RST    = 16'h0000;
  localparam logic [15:0] CAL_RES_RST  = 16'h0000;
  localparam logic [7:0]  DOW_LAST     = 8'h06;   // day-of-week wraps 6 -> 0
  localparam logic [15:0] CAL_TIMEOUT_BASE = 16'h0080; // limit = base << timeout select

  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned TICK_PERIOD_NS  = 10_000_000;
  localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned WDO_PULSE_MS    = 250;
  localparam logic [4:0]  WDO_PULSE_TICKS = 5'(WDO_PULSE_MS / TICK_MS);

  // Register request from the serial port, one-cycle strobes
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] data;
  } reg_req_t;

  // Report from the calibration engine
  typedef struct packed {
    logic        done;    // one-cycle pulse at end of a run
    logic        manual;  // run was the host command, not automatic
    logic        error;   // engine detected a failure
    logic [15:0] elapsed; // internal calibration timing
    logic [15:0] res_int;
    logic [15:0] res_frac;
  } cal_report_t;

endpackage

`default_nettype wire

// File: src/spi_reg_port.sv
// Serial register port: opcode then one 16-bit word, oversampled by the system clock
`default_nettype none

module spi_reg_port
  import rtc_pkg::*;
(
  input  wire logic            clk_i,      // System clock
  input  wire logic            rst_n_i,    // Async reset, active low
  input  wire logic            sck_i,      // Serial clock pin
  input  wire logic            ce_n_i,     // Chip enable pin, active low
  input  wire logic            din_i,      // Serial data in pin
  input  wire logic [15:0]     rd_data_i,  // Read word for req_o.addr
  output rtc_pkg::reg_req_t    req_o,      // Register strobes
  output logic                 dout_o,     // Serial data out
  output logic                 dout_oe_o   // Drive enable for serial data out
);

  logic [1:0]  sck_s;
  logic [1:0]  ce_s;
  logic [1:0]  din_s;
  logic        sck_q;
  logic        fall;
  logic        rise;
  logic [4:0]  bit_cnt;
  logic [14:0] shift;
  logic [7:0]  opcode;
  logic [15:0] tx;
  logic        reading;
  logic [7:0]  next_opcode;

  // Two-flop synchronisers for all pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_s <= 2'h0;
      ce_s  <= 2'h3;
      din_s <= 2'h0;
      sck_q <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], sck_i};
      ce_s  <= {ce_s[0], ce_n_i};
      din_s <= {din_s[0], din_i};
      sck_q <= sck_s[1];
    end
  end

  assign fall        = sck_q & ~sck_s[1];
  assign rise        = ~sck_q & sck_s[1];
  assign next_opcode = {shift[6:0], din_s[1]};

  // Receive: data in taken on falling serial clock edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt <= 5'h00;
      shift   <= 15'h0000;
      opcode  <= 8'h00;
      req_o   <= '0;
    end else begin
      req_o.wr <= 1'b0;
      req_o.rd <= 1'b0;
      if (ce_s[1]) begin
        bit_cnt <= 5'h00;
      end else if (fall) begin
        shift <= {shift[13:0], din_s[1]};
        if (bit_cnt != 5'h1f) begin
          bit_cnt <= bit_cnt + 5'h01; // Saturates; extra bits ignored
        end
        if (bit_cnt == 5'd7) begin
          opcode <= next_opcode;
          if (next_opcode >= RD_OP_FIRST) begin
            req_o.rd   <= 1'b1; // Snapshot taken at this instant
            req_o.addr <= next_opcode[6:0];
          end
        end
        if (bit_cnt == 5'd23 && opcode >= WR_OP_FIRST && opcode <= WR_OP_LAST) begin
          req_o.wr   <= 1'b1;
          req_o.addr <= opcode[6:0];
          req_o.data <= {shift, din_s[1]};
        end
      end
    end
  end

  // Transmit: next bit presented on rising edges, MSB first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx        <= 16'h0000;
      reading   <= 1'b0;
      dout_o    <= 1'b0;
      dout_oe_o <= 1'b0;
    end else if (ce_s[1]) begin
      reading   <= 1'b0;
      dout_oe_o <= 1'b0;
    end else if (req_o.rd) begin
      tx      <= rd_data_i;
      reading <= 1'b1;
    end else if (rise && reading && bit_cnt >= 5'd8) begin
      dout_o    <= tx[15];
      dout_oe_o <= 1'b1;
      tx        <= {tx[14:0], 1'b0};
    end
  end

endmodule

`default_nettype wire

// File: src/rtc_alarm_watchdog_irq.sv
// Clock/calendar, alarm, watchdog, tamper, calibration result guard and interrupt status
`default_nettype none

// Behaviour
// - Failed calibration keeps old integer and fraction results in use.
// - Calibration over the selected timeout sets timeout flag and interrupt.
// - Time and calendar kept in BCD, readable and writable as words.
// - Date rolls over for short months, leap years through 2099.
// - Hour format bit clear: 24-hour, bit 5 is twenty-hours digit.
// - Hour format bit set: 12-hour, bit 5 is PM.
// - Day of week increments at midnight, host-chosen sequential values.
// - Alarm active when a match enable set; compares minutes and/or hours.
// - Alarm match sets alarm flag and interrupt when enabled.
// - Watchdog is 16-bit BCD down-counter in 10 ms units from seed.
// - Watchdog counts only while watchdog enable is set.
// - Watchdog read returns snapshot of current count.
// - Any watchdog write reloads the countdown immediately.
// - Count to zero sets watchdog flag and pulses output low 250 ms.
// - Watchdog flag sticky until written 0; clearing releases pulse at once.
// - A zero seed never sets the watchdog flag.
// - Case-switch event sets control and status tamper flags, interrupt.
// - Status flags set on event or command completion.
// - Status read clears flags; events during the read are kept.
// - Interrupt asserted while any status flag set, until read clear.
// - Interrupt works only once the interrupt enable bit is set.
module rtc_alarm_watchdog_irq
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = rtc_pkg::TICK_CYCLES // Clocks per hundredth second
) (
  input  wire logic                  MCLK_I,                     // System clock, 40 MHz
  input  wire logic                  RESETN_I,                   // Async reset, active low
  input  wire logic                  SCK_I,                      // Serial clock
  input  wire logic                  CE_N_I,                     // Chip enable, active low
  input  wire logic                  DIN_I,                      // Serial data in
  output logic                       DOUT_O,                     // Serial data out
  output logic                       DOUT_OE_O,                  // Serial data out enable
  input  wire logic                  CASE_SWITCH_I,              // Tamper switch pin
  input  wire rtc_pkg::cal_report_t  CAL_REPORT_I,               // Calibration engine report
  output logic [15:0]                CAL_RESULT_INTEGER_O,       // Coefficient in use, integer
  output logic [15:0]                CAL_RESULT_FRACTION_O,      // Coefficient in use, fraction
  output logic [2:0]                 MEASURE_TIMEOUT_SEL_O,      // Timeout select to engine
  output logic                       INT_N_O,                    // Interrupt, active low
  output logic                       WATCHDOG_PULSE_OUT_N_O,     // Open-drain level, always low
  output logic                       WATCHDOG_PULSE_OUT_N_OE_O   // High while pulse pulls low
);

  localparam int PW = $clog2(TICK_CYCLES_P + 1);

  reg_req_t          req;
  logic [15:0]       rd_data;
  logic [PW-1:0]     presc;
  logic              tick;
  logic [7:0]        hund, sec, mins, hour, dow, date, month, year;
  logic [7:0]        alarm_min, alarm_hr;
  logic [15:0]       wd_cnt;
  logic              alarm_minute_match_en, alarm_hour_match_en;
  logic              watchdog_enable, watchdog_fired, case_switch_control_flag;
  logic              int_enable;
  logic [STATUS_W-1:0] status, next_status_set;
  logic [4:0]        pulse_cnt;
  logic              pulse_on;
  logic [1:0]        case_s;
  logic              case_q;
  logic              tamper_ev;
  logic              alarm_prev, alarm_match, alarm_ev;
  logic              c_sec, c_min, c_hr, midnight, c_month, c_year;
  logic              wd_expire, wf_clear_wr;
  logic [15:0]       cal_limit;
  logic              cal_timeout, cal_fail;
  logic              wr_secs, wr_mh, wr_dd, wr_my, wr_wd, wr_al, wr_ctl, wr_cal;

  // BCD helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (v[4*i +: 4] == 4'h0) begin
          r[4*i +: 4] = 4'h9;
        end else begin
          r[4*i +: 4] = v[4*i +: 4] - 4'h1;
          borrow      = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // Leap test on BCD year: tens even -> units 0/4/8, tens odd -> units 2/6
  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) begin
      return leap ? 8'h29 : 8'h28;
    end
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      return 8'h30;
    end
    return 8'h31;
  endfunction

  function automatic logic [7:0] next_hour(input logic [7:0] h);
    logic [7:0] r;
    r = h;
    if (!h[HOUR_FORMAT_BIT]) begin
      r[5:0] = (h[5:0] == 6'h23) ? 6'h00 : 6'(bcd_inc({2'b00, h[5:0]}));
    end else if (h[4:0] == 5'h11) begin
      r[4:0]        = 5'h12;
      r[HOUR_PM_BIT] = ~h[HOUR_PM_BIT];
    end else if (h[4:0] == 5'h12) begin
      r[4:0] = 5'h01;
    end else begin
      r[4:0] = 5'(bcd_inc({3'b000, h[4:0]}));
    end
    return r;
  endfunction

  // Serial register port
  spi_reg_port u_port (
    .clk_i     (MCLK_I),
    .rst_n_i   (RESETN_I),
    .sck_i     (SCK_I),
    .ce_n_i    (CE_N_I),
    .din_i     (DIN_I),
    .rd_data_i (rd_data),
    .req_o     (req),
    .dout_o    (DOUT_O),
    .dout_oe_o (DOUT_OE_O)
  );

  assign wr_secs = req.wr && req.addr == REG_SECONDS;
  assign wr_mh   = req.wr && req.addr == REG_MINS_HRS;
  assign wr_dd   = req.wr && req.addr == REG_DAY_DATE;
  assign wr_my   = req.wr && req.addr == REG_MON_YEAR;
  assign wr_wd   = req.wr && req.addr == REG_WATCHDOG;
  assign wr_al   = req.wr && req.addr == REG_ALARM;
  assign wr_ctl  = req.wr && req.addr == REG_RTC_CTRL;
  assign wr_cal  = req.wr && req.addr == REG_CAL_CTRL;

  // Hundredth-second tick; writing the seconds word restarts the fraction
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      presc <= '0;
    end else if (wr_secs || presc == PW'(TICK_CYCLES_P - 1)) begin
      presc <= '0;
    end else begin
      presc <= presc + PW'(1);
    end
  end
  assign tick = (presc == PW'(TICK_CYCLES_P - 1));

  // Ripple carries through the calendar
  assign c_sec    = tick && hund == 8'h99;
  assign c_min    = c_sec && sec == 8'h59;
  assign c_hr     = c_min && mins == 8'h59;
  assign midnight = c_hr && (hour[HOUR_FORMAT_BIT] ? hour[5:0] == 6'h31 : hour[5:0] == 6'h23);
  assign c_month  = midnight && date == month_days(month, year);
  assign c_year   = c_month && month == 8'h12;

  // Time of day in BCD; host writes take priority over counting
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      {hund, sec}  <= SECONDS_RST;
      {mins, hour} <= MINS_HRS_RST;
    end else begin
      if (wr_secs) begin
        {hund, sec} <= req.data;
      end else begin
        if (tick) hund <= (hund == 8'h99) ? 8'h00 : bcd_inc(hund);
        if (c_sec) sec <= (sec == 8'h59) ? 8'h00 : bcd_inc(sec);
      end
      if (wr_mh) begin
        {mins, hour} <= req.data;
      end else begin
        if (c_min) mins <= (mins == 8'h59) ? 8'h00 : bcd_inc(mins);
        if (c_hr) hour <= next_hour(hour);
      end
    end
  end

  // Calendar; day of week steps only at midnight
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      {dow, date}   <= DAY_DATE_RST;
      {month, year} <= MON_YEAR_RST;
    end else begin
      if (wr_dd) begin
        {dow, date} <= req.data;
      end else if (midnight) begin
        dow  <= (dow == DOW_LAST) ? 8'h00 : dow + 8'h01;
        date <= c_month ? 8'h01 : bcd_inc(date);
      end
      if (wr_my) begin
        {month, year} <= req.data;
      end else if (c_month) begin
        month <= c_year ? 8'h01 : bcd_inc(month);
        if (c_year) year <= (year == 8'h99) ? 8'h00 : bcd_inc(year);
      end
    end
  end

  // Alarm on the rising edge of a match, so one match sets the flag once
  assign alarm_match = (alarm_minute_match_en || alarm_hour_match_en) &&
                       (!alarm_minute_match_en || alarm_min == mins) &&
                       (!alarm_hour_match_en || alarm_hr[6:0] == hour[6:0]);
  assign alarm_ev    = alarm_match && !alarm_prev;

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      {alarm_min, alarm_hr} <= ALARM_RST;
      alarm_prev            <= 1'b0;
    end else begin
      if (wr_al) {alarm_min, alarm_hr} <= req.data;
      alarm_prev <= alarm_match;
    end
  end

  // Watchdog countdown; fires only on reaching zero, so a zero seed is inert
  assign wd_expire   = tick && watchdog_enable && wd_cnt == 16'h0001 && !wr_wd;
  assign wf_clear_wr = wr_ctl && !req.data[CTRL_WF_BIT];

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wd_cnt <= WATCHDOG_RST;
    end else if (wr_wd) begin
      wd_cnt <= req.data;
    end else if (tick && watchdog_enable && wd_cnt != 16'h0000) begin
      wd_cnt <= bcd_dec(wd_cnt);
    end
  end

  // Control bits; hardware sets win over a clearing write
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      alarm_minute_match_en    <= 1'b0;
      alarm_hour_match_en      <= 1'b0;
      watchdog_enable          <= 1'b0;
      watchdog_fired           <= 1'b0;
      case_switch_control_flag <= 1'b0;
    end else begin
      if (wr_ctl) begin
        alarm_minute_match_en <= req.data[CTRL_AM1_BIT];
        alarm_hour_match_en   <= req.data[CTRL_AM2_BIT];
        watchdog_enable       <= req.data[CTRL_WDEN_BIT];
      end
      if (wd_expire) watchdog_fired <= 1'b1;
      else if (wf_clear_wr) watchdog_fired <= 1'b0;
      if (tamper_ev) case_switch_control_flag <= 1'b1;
      else if (wr_ctl && !req.data[CTRL_CASE_SWITCH_CONTROL_FLAG_BIT]) case_switch_control_flag <= 1'b0;
    end
  end

  // Watchdog low pulse, counted in hundredth ticks
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pulse_cnt <= 5'h00;
      pulse_on  <= 1'b0;
    end else if (wd_expire) begin
      pulse_cnt <= WDO_PULSE_TICKS;
      pulse_on  <= 1'b1;
    end else if (wf_clear_wr) begin
      pulse_on <= 1'b0;
    end else if (tick && pulse_on) begin
      pulse_cnt <= pulse_cnt - 5'h01;
      if (pulse_cnt == 5'h01) pulse_on <= 1'b0;
    end
  end
  assign WATCHDOG_PULSE_OUT_N_O    = 1'b0; // Open drain: only the enable moves
  assign WATCHDOG_PULSE_OUT_N_OE_O = pulse_on;

  // Tamper switch: synchronised, event on rising level
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      case_s <= 2'h0;
      case_q <= 1'b0;
    end else begin
      case_s <= {case_s[0], CASE_SWITCH_I};
      case_q <= case_s[1];
    end
  end
  assign tamper_ev = case_s[1] && !case_q;

  // Calibration results kept unless the run succeeds
  assign cal_limit   = CAL_TIMEOUT_BASE << MEASURE_TIMEOUT_SEL_O;
  assign cal_timeout = CAL_REPORT_I.done && CAL_REPORT_I.elapsed > cal_limit;
  assign cal_fail    = CAL_REPORT_I.done && (CAL_REPORT_I.error || cal_timeout);

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CAL_RESULT_INTEGER_O  <= CAL_RES_RST;
      CAL_RESULT_FRACTION_O <= CAL_RES_RST;
      MEASURE_TIMEOUT_SEL_O <= 3'h0;
      int_enable            <= 1'b0;
    end else begin
      if (CAL_REPORT_I.done && !cal_fail) begin
        CAL_RESULT_INTEGER_O  <= CAL_REPORT_I.res_int;
        CAL_RESULT_FRACTION_O <= CAL_REPORT_I.res_frac;
      end
      if (wr_cal) begin
        int_enable            <= req.data[CAL_INTEN_BIT];
        MEASURE_TIMEOUT_SEL_O <= req.data[CAL_TOSEL_LSB +: 3];
      end
    end
  end

  // Status flags: a read clears, a same-cycle event survives the clear
  always_comb begin
    next_status_set              = '0;
    next_status_set[ST_CAL_BIT]  = CAL_REPORT_I.done && CAL_REPORT_I.manual && !cal_fail;
    next_status_set[ST_TO_BIT]   = cal_timeout;
    next_status_set[ST_AF_BIT]   = alarm_ev;
    next_status_set[ST_CASE_SWITCH_IRQ_FLAG_BIT] = tamper_ev;
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      status <= '0;
    end else if (req.rd && req.addr == REG_STATUS) begin
      status <= next_status_set;
    end else begin
      status <= status | next_status_set;
    end
  end

  // Interrupt pin, registered, active low
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      INT_N_O <= 1'b1;
    end else begin
      INT_N_O <= !(int_enable && |status);
    end
  end

  // Read mux; sampled by the port on the read strobe, giving a snapshot
  always_comb begin
    rd_data = 16'h0000;
    unique case (req.addr)
      REG_SECONDS:  rd_data = {hund, sec};
      REG_MINS_HRS: rd_data = {mins, hour};
      REG_DAY_DATE: rd_data = {dow, date};
      REG_MON_YEAR: rd_data = {month, year};
      REG_WATCHDOG: rd_data = wd_cnt;
      REG_ALARM:    rd_data = {alarm_min, alarm_hr};
      REG_RTC_CTRL: rd_data = {11'h000, case_switch_control_flag, watchdog_fired, watchdog_enable,
                               alarm_hour_match_en, alarm_minute_match_en};
      REG_CAL_CTRL: rd_data = {int_enable, 12'h000, MEASURE_TIMEOUT_SEL_O};
      REG_CAL_INT:  rd_data = CAL_RESULT_INTEGER_O;
      REG_CAL_FRAC: rd_data = CAL_RESULT_FRACTION_O;
      REG_STATUS:   rd_data = {12'h000, status};
      default:      rd_data = 16'h0000;
    endcase
  end

endmodule

`default_nettype wire

// File: tb/spi_host_model.sv
// Host serial master
`default_nettype none
module spi_host_model (
  input  wire logic clk_i,  // Bench clock
  input  wire logic dout_i, // Device data
  output logic      sck_o,  // Serial clock
  output logic      ce_n_o, // Chip enable
  output logic      din_o   // Data to device
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: clock low, deselected
  initial begin
    sck_o = 1'b0;
    ce_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Half period of four clocks; rd gets the last 16 bits
  task automatic xfer(input logic [7:0] op, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {op, wd};
    ce_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (4) @(negedge clk_i);
      din_o = sh[i];
      sck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      rd = {rd[14:0], dout_i};
      sck_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    ce_n_o = 1'b1;
    din_o = ~din_o; // Not left stale
    repeat (6) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: tb/rtc_chk.sv
// Port assertions
`default_nettype none
module rtc_chk
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = 20 // Tick length
) (
  input wire logic                 MCLK_I,                    // Clock
  input wire logic                 RESETN_I,                  // Reset
  input wire logic                 CE_N_I,                    // Enable
  input wire rtc_pkg::cal_report_t CAL_REPORT_I,              // Report
  input wire logic [15:0]          CAL_RESULT_INTEGER_O,      // In use
  input wire logic [2:0]           MEASURE_TIMEOUT_SEL_O,     // Select
  input wire logic                 INT_N_O,                   // Interrupt
  input wire logic                 WATCHDOG_PULSE_OUT_N_O,    // Level
  input wire logic                 WATCHDOG_PULSE_OUT_N_OE_O  // Pulled low
);
  localparam int PULSE = WDO_PULSE_TICKS * TICK_CYCLES_P;
  logic [3:0] idle; // Clocks since a frame
  int         held; // Clocks pulled low
  logic       fail; // Failed run
  assign fail = CAL_REPORT_I.error | (CAL_REPORT_I.elapsed > (CAL_TIMEOUT_BASE << MEASURE_TIMEOUT_SEL_O));
  // Frame distance and pulse length
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      idle <= 4'hf;
      held <= 0;
    end else begin
      idle <= CE_N_I ? idle + 4'(idle != 4'hf) : 4'h0;
      held <= WATCHDOG_PULSE_OUT_N_OE_O ? held + 1 : 0;
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  a_cal_fail_hold: assert property (CAL_REPORT_I.done && fail |=> $stable(CAL_RESULT_INTEGER_O))
    else $error("result lost");
  a_cal_ok_load: assert property (CAL_REPORT_I.done && !fail |=>
    CAL_RESULT_INTEGER_O == $past(CAL_REPORT_I.res_int)) else $error("result not loaded");
  a_cal_quiet: assert property ($changed(CAL_RESULT_INTEGER_O) |-> $past(CAL_REPORT_I.done))
    else $error("stray result");
  a_sel_frame: assert property ($changed(MEASURE_TIMEOUT_SEL_O) |-> idle < 4'hc) else $error("stray select");
  a_int_release: assert property ($rose(INT_N_O) |-> idle < 4'hc) else $error("interrupt dropped");
  a_wdo_level: assert property (WATCHDOG_PULSE_OUT_N_O == 1'b0) else $error("pin level high");
  a_wdo_max: assert property (held <= PULSE + 2) else $error("pulse too long");
  a_wdo_release: assert property ($fell(WATCHDOG_PULSE_OUT_N_OE_O) |->
    held >= PULSE - 2 || idle < 4'hc) else $error("pulse cut short");
endmodule
bind rtc_alarm_watchdog_irq rtc_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) rtc_chk_inst (.MCLK_I, .RESETN_I, .CE_N_I,
  .CAL_REPORT_I, .CAL_RESULT_INTEGER_O, .MEASURE_TIMEOUT_SEL_O, .INT_N_O, .WATCHDOG_PULSE_OUT_N_O,
  .WATCHDOG_PULSE_OUT_N_OE_O);
`default_nettype wire

// File: tb/test_rtc_alarm_watchdog_irq.sv
// Bench for the clock and watchdog block
`default_nettype none
module test_rtc_alarm_watchdog_irq;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tamper = 1'b0;
  cal_report_t cal = '0;
  logic        sck, ce_n, din, dout, oe, int_n, watchdog_pulse_out_n, wdo_oe;
  logic [15:0] c_int, c_frac, r;
  logic [2:0]  tsel;
  int          n_errors = 0;
  int          tests_run = 0;
  // Short tick, short run
  rtc_alarm_watchdog_irq #(.TICK_CYCLES_P(20)) rtc_alarm_watchdog_irq_inst (.MCLK_I(clk), .RESETN_I(rst_n),
    .SCK_I(sck), .CE_N_I(ce_n), .DIN_I(din), .DOUT_O(dout), .DOUT_OE_O(oe), .CASE_SWITCH_I(tamper),
    .CAL_REPORT_I(cal), .CAL_RESULT_INTEGER_O(c_int), .CAL_RESULT_FRACTION_O(c_frac), .MEASURE_TIMEOUT_SEL_O(tsel),
    .INT_N_O(int_n), .WATCHDOG_PULSE_OUT_N_O(watchdog_pulse_out_n), .WATCHDOG_PULSE_OUT_N_OE_O(wdo_oe));
  spi_host_model spi_host_model_inst (.clk_i(clk), .dout_i(dout), .sck_o(sck), .ce_n_o(ce_n), .din_o(din));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    spi_host_model_inst.xfer({1'b0, a}, d, r);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    spi_host_model_inst.xfer({1'b1, a}, 16'h0, r);
    chk(r, e);
  endtask
  task automatic cal_run(input logic err, man, input logic [15:0] el, v);
    @(negedge clk);
    cal = '{1'b1, man, err, el, v, v};
    @(negedge clk);
    cal.done = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic wait_oe(input logic v, output int n);
    for (n = 0; n < 2000 && wdo_oe !== v; n++) @(negedge clk);
  endtask
  // Tamper, interrupt off then on
  task automatic t_tamper();
    rd(REG_DAY_DATE, DAY_DATE_RST);
    tamper = 1'b1;
    repeat (8) @(negedge clk);
    chk(16'(int_n), 16'h1);
    wr(REG_CAL_CTRL, 16'h8000);
    chk(16'(int_n), 16'h0);
    rd(REG_RTC_CTRL, 16'h10);
    rd(REG_STATUS, 16'h8);
    rd(REG_STATUS, 16'h0);
    chk(16'(int_n), 16'h1);
    wr(REG_RTC_CTRL, 16'h0);
  endtask
  // Good, failed and timed-out runs
  task automatic t_cal();
    cal_run(0, 1, 16'h80, 16'h1234);
    rd(REG_STATUS, 16'h1);
    cal_run(1, 1, 16'h10, 16'haaaa);
    cal_run(0, 0, 16'h81, 16'hcccc);
    chk(c_int, 16'h1234);
    chk(c_frac, 16'h1234);
    rd(REG_STATUS, 16'h2);
  endtask
  // Month end, midnight alarm, 12-hour run
  task automatic t_midnight();
    wr(REG_MON_YEAR, 16'h0223);
    wr(REG_DAY_DATE, 16'h0328);
    wr(REG_ALARM, 16'h0);
    wr(REG_MINS_HRS, 16'h5923);
    wr(REG_SECONDS, 16'h59);
    wr(REG_RTC_CTRL, 16'h3);
    repeat (2400) @(negedge clk);
    chk(16'(int_n), 16'h0);
    rd(REG_MINS_HRS, 16'h0);
    rd(REG_DAY_DATE, 16'h0401);
    rd(REG_MON_YEAR, 16'h0323);
    rd(REG_STATUS, 16'h4);
    wr(REG_RTC_CTRL, 16'h0);
    wr(REG_MINS_HRS, 16'h5970);
    wr(REG_SECONDS, 16'h59);
    repeat (2400) @(negedge clk);
    rd(REG_MINS_HRS, 16'h71);
  endtask
  // Zero seed, snapshot, cut and full pulse
  task automatic t_watchdog();
    int n;
    wr(REG_RTC_CTRL, 16'h4);
    repeat (200) @(negedge clk);
    rd(REG_RTC_CTRL, 16'h4);
    wr(REG_WATCHDOG, 16'h9999);
    spi_host_model_inst.xfer({1'b1, REG_WATCHDOG}, 16'h0, r);
    chk({r[15:8], 8'h0}, 16'h9900);
    wr(REG_WATCHDOG, 16'h20);
    wait_oe(1'b1, n);
    rd(REG_RTC_CTRL, 16'hc);
    wr(REG_RTC_CTRL, 16'h4);
    chk(16'(wdo_oe), 16'h0);
    wr(REG_WATCHDOG, 16'h2);
    wait_oe(1'b1, n);
    wait_oe(1'b0, n);
    chk(16'((n + 5) / 10), 16'(WDO_PULSE_TICKS * 2));
  endtask
  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reset, then scenarios
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_tamper();
    t_cal();
    t_midnight();
    t_watchdog();
    final_report();
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
